// ==== verilog/iss_pkg.sv ====
/*
  Shared constants and types for the indexer step sequencer.
  Assumes a single 20 MHz clock and an APB register port.
*/
`default_nettype none
package iss_pkg;
  // clock and response times
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int RESP_MIN_MS = 2;
  localparam int RESP_MOTION_MAX_MS = 6;
  localparam int RESP_INPOS_MAX_MS = 8;
  localparam int RESP_PROGRAMMABLE_OUTPUTS_MAX_MS = 6;
  localparam int RESP_MOTION_SPECIAL_MS = 16;
  localparam int RESP_INPOS_SPECIAL_MS = 14;
  localparam int RESP_PROGRAMMABLE_OUTPUTS_SPECIAL_MS = 10;
  // firmware revision that honours per-step accel/decel
  localparam int FW_REV_ACCEL = 4;
  localparam int FW_REV_DEFAULT = 4;
  // step table shape
  localparam int STEP_COUNT = 128;
  localparam int STEP_W = 7;
  localparam int LOOP_W = 17;
  localparam logic [7:0] NEXT_TERMINATE = 8'h80;
  localparam logic [LOOP_W-1:0] LOOP_DEFAULT = 17'h0_0001;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STEP_INDEX = 8'h08;
  localparam logic [7:0] REG_STEP_LO = 8'h0C;
  localparam logic [7:0] REG_STEP_HI = 8'h10;
  // control bits, write one to clear
  localparam int CTRL_CLR_CONFLICT = 0;
  localparam int CTRL_CLR_LOCKED = 1;

  typedef enum logic [1:0] {SEQ_CANCELLED, SEQ_OPERATING, SEQ_STOPPED} iss_seq_t;
  typedef enum logic [1:0] {PH_DELAY, PH_ISSUE, PH_TRIG, PH_WAIT} iss_phase_t;
  typedef enum logic [1:0] {TGT_NONE, TGT_FINITE, TGT_PLUS_UNBOUNDED, TGT_MINUS_UNBOUNDED} iss_target_t;
  typedef enum logic [2:0] {TRG_INPOS, TRG_NEAR, TRG_DONE, TRG_SELECT} iss_trig_t;

  typedef struct packed {
    logic spare;
    logic [7:0] next;
    iss_trig_t trigKind;
    logic [2:0] trigSel;
    logic regDistSet;
    logic [15:0] waitMs;
  } iss_step_lo_t;

  typedef struct packed {
    logic [LOOP_W-1:0] loopCount;
    iss_target_t target;
    logic [3:0] accel;
    logic [3:0] decel;
    logic [4:0] programmable_outputs;
  } iss_step_hi_t;

  typedef struct packed {
    iss_step_hi_t hi;
    iss_step_lo_t lo;
  } iss_step_t;

  typedef struct packed {
    logic [STEP_W-1:0] step;
    iss_target_t target;
    logic [3:0] accel;
    logic [3:0] decel;
  } iss_move_t;

  typedef struct packed {
    logic motionDone;
    logic inPosition;
    logic nearPosition;
  } iss_motion_fb_t;
endpackage
`default_nettype wire

// ==== verilog/iss_sync_edge.sv ====
/*
  Two-flop synchroniser with level, rise and fall detection.
  Assumes inputs may change at any time relative to mclk.
*/
`timescale 1ns/1ns
`default_nettype none
module iss_sync_edge #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // raw and conditioned signals
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  // meta feeds only the second stage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      level <= '0;
      prev <= '0;
    end else begin
      meta <= din;
      level <= meta;
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule
`default_nettype wire

// ==== verilog/iss_ms_timer.sv ====
/*
  Millisecond down-timer: load n, pulse done after n ms.
  Assumes one start per interval; abort drops a running count.
*/
`timescale 1ns/1ns
`default_nettype none
module iss_ms_timer #(
  parameter int CYCLES_PER_MS = 20000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [15:0] loadMs,
  // status
  output logic busy,
  output logic done
);
  localparam int PRE_W = $clog2(CYCLES_PER_MS + 1);
  logic [PRE_W-1:0] pre;
  logic [15:0] msLeft;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      done <= 1'b0;
      pre <= '0;
      msLeft <= '0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        msLeft <= loadMs;
        pre <= '0;
      end else if (busy) begin
        if (msLeft == 16'h0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else if (pre == PRE_W'(CYCLES_PER_MS - 1)) begin
          pre <= '0;
          msLeft <= msLeft - 16'h0001;
        end else begin
          pre <= pre + PRE_W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/iss_step_sequencer.sv ====
/*
  Indexer step sequencer: run/stop/cancel control over a stored step table,
  APB register slave for table edits and status.
  Assumes run, cancel and select inputs are active high, and that the motion
  unit acknowledges moves through motion_done / in-position / near-position.
*/
// Notes on behaviour
// R1 - new move during move: conflict error, halt
// R2 - after conflict: rerun resumes at successor step
// R3 - mid-move switch only unbounded, no registration
// R4 - table edits only while cancelled, else locked
// R5 - start from cancelled captures seven select lines
// R6 - run drop: stop, abandon current move
// R7 - restart from stopped keeps step, no capture
// R8 - restart allowed while motor still decelerating
// R9 - cancel edge, run low, stopped: cancelled
// R10 - three states, cancelled after reset
// R11 - error resume skips step unless loops remain
// R12 - normal response windows 2-6, 2-8, 2-6 ms
// R13 - special response windows up to 16/14/10 ms
// R14 - accel/decel fields used from revision four
// R15 - repeat count runs first, then successor
// R16 - successor index or terminate, default terminate
// R17 - wait n ms after chosen trigger
// R18 - run and cancel synchronised and edge-detected
`timescale 1ns/1ns
`default_nettype none
module iss_step_sequencer
  import iss_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES,
  parameter int FW_REVISION = FW_REV_DEFAULT
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host discrete inputs
  input wire logic runRequest,
  input wire logic programCancel,
  input wire logic [STEP_W-1:0] stepSelect,
  // motion unit
  input wire iss_motion_fb_t motionFb,
  output iss_move_t moveCmd,
  output logic moveStart,
  output logic moveStop,
  output logic [4:0] programmableOutputs,
  // state and errors
  output iss_seq_t seqState,
  output logic sequencingConflictError,
  output logic tableLockedError
);
  iss_phase_t phase;
  logic [STEP_W-1:0] curStep;
  logic [LOOP_W-1:0] loopLeft;
  logic errStop;
  logic moveBusy;
  iss_target_t activeTarget;
  logic activeRegDist;
  logic [STEP_W-1:0] stepIndex;
  iss_step_lo_t stagedLo;
  iss_step_t stepTable [STEP_COUNT];
  logic [STEP_COUNT-1:0] stepValid;

  // unwritten entries read as the factory default step
  function automatic iss_step_t stepOf(input logic [STEP_W-1:0] idx);
    iss_step_t s;
    s = '0;
    if (stepValid[idx]) begin
      s = stepTable[idx];
    end else begin
      s.hi.loopCount = LOOP_DEFAULT;
      s.lo.next = NEXT_TERMINATE; // [R16]
      s.lo.trigKind = TRG_INPOS;
    end
    return s;
  endfunction

  function automatic logic isUnbounded(input iss_target_t t);
    return (t == TGT_PLUS_UNBOUNDED) || (t == TGT_MINUS_UNBOUNDED);
  endfunction

  // input conditioning
  logic [1:0] syncLevel;
  logic [1:0] syncRise;
  logic [1:0] syncFall;
  logic runLevel;
  logic runRise;
  logic runFall;
  logic cancelRise;

  iss_sync_edge #(.WIDTH(2)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din({programCancel, runRequest}),
    .level(syncLevel),
    .rise(syncRise),
    .fall(syncFall)
  );
  assign runLevel = syncLevel[0]; // [R18]
  assign runRise = syncRise[0];
  assign runFall = syncFall[0];
  assign cancelRise = syncRise[1];

  // step decode and advance
  iss_step_t curEntry;
  iss_step_t selEntry;
  logic advEnd;
  logic [STEP_W-1:0] advStep;
  logic [LOOP_W-1:0] advLoop;
  logic trigActive;
  logic speedOk;
  logic conflict;

  iss_step_t nextEntry;
  iss_step_t idxEntry;

  // a process, not assigns, so that table writes re-run the lookups
  always_comb begin
    curEntry = stepOf(curStep);
    selEntry = stepOf(stepSelect);
    nextEntry = stepOf(curEntry.lo.next[STEP_W-1:0]);
    idxEntry = stepOf(stepIndex);
  end

  always_comb begin
    advEnd = 1'b0;
    advStep = curStep;
    advLoop = loopLeft - LOOP_W'(1);
    if (loopLeft > LOOP_DEFAULT) begin
      advStep = curStep; // [R15]
    end else if (curEntry.lo.next == NEXT_TERMINATE) begin
      advEnd = 1'b1; // [R16]
    end else begin
      advStep = curEntry.lo.next[STEP_W-1:0];
      advLoop = nextEntry.hi.loopCount;
    end
  end

  always_comb begin
    trigActive = 1'b0;
    unique case (curEntry.lo.trigKind)
      TRG_INPOS: trigActive = motionFb.inPosition; // [R17]
      TRG_NEAR: trigActive = motionFb.nearPosition;
      TRG_DONE: trigActive = motionFb.motionDone;
      TRG_SELECT: trigActive = (curEntry.lo.trigSel < 3'h7) && stepSelect[curEntry.lo.trigSel];
      default: trigActive = 1'b0;
    endcase
    // feedback still shows the previous move in the issue cycle
    if (moveStart) begin
      trigActive = 1'b0;
    end
  end

  // speed change in flight only between unbounded moves without registration
  assign speedOk = isUnbounded(curEntry.hi.target) && isUnbounded(activeTarget)
    && !curEntry.lo.regDistSet && !activeRegDist; // [R3]
  assign conflict = (seqState == SEQ_OPERATING) && !runFall && (phase == PH_ISSUE)
    && (curEntry.hi.target != TGT_NONE) && moveBusy && !speedOk; // [R1]

  // timer shared by the start delay and the step wait
  logic timerStart;
  logic timerAbort;
  logic timerDone;
  logic [15:0] timerLoad;
  logic restart;

  assign restart = runRise && (seqState != SEQ_OPERATING);
  assign timerStart = restart || ((seqState == SEQ_OPERATING) && !runFall && (phase == PH_TRIG) && trigActive);
  assign timerLoad = restart ? 16'(RESP_MIN_MS) : curEntry.lo.waitMs; // [R12] [R17]
  assign timerAbort = (seqState == SEQ_OPERATING) && runFall;

  iss_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer (
    .mclk(mclk),
    .nrst(nrst),
    .start(timerStart),
    .abort(timerAbort),
    .loadMs(timerLoad),
    .busy(),
    .done(timerDone)
  );

  // sequencing
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seqState <= SEQ_CANCELLED; // [R10]
      phase <= PH_DELAY;
      curStep <= '0;
      loopLeft <= '0;
      errStop <= 1'b0;
      moveStart <= 1'b0;
      moveStop <= 1'b0;
      moveBusy <= 1'b0;
      moveCmd <= '0;
      programmableOutputs <= '0;
      activeTarget <= TGT_NONE;
      activeRegDist <= 1'b0;
    end else begin
      moveStart <= 1'b0;
      moveStop <= 1'b0;
      if (motionFb.motionDone && !moveStart) begin
        moveBusy <= 1'b0;
      end
      unique case (seqState)
        SEQ_CANCELLED: begin
          if (runRise) begin
            curStep <= stepSelect; // [R5]
            loopLeft <= selEntry.hi.loopCount;
            errStop <= 1'b0;
            phase <= PH_DELAY;
            seqState <= SEQ_OPERATING;
          end
        end
        SEQ_OPERATING: begin
          if (runFall) begin
            seqState <= SEQ_STOPPED; // [R6]
            moveStop <= 1'b1;
            moveBusy <= 1'b0;
          end else begin
            unique case (phase)
              PH_DELAY: begin
                if (timerDone) begin
                  phase <= PH_ISSUE;
                end
              end
              PH_ISSUE: begin
                if (conflict) begin
                  seqState <= SEQ_STOPPED; // [R1] [R3]
                  errStop <= 1'b1;
                  moveStop <= 1'b1;
                  moveBusy <= 1'b0;
                end else begin
                  programmableOutputs <= curEntry.hi.programmable_outputs;
                  phase <= PH_TRIG;
                  if (curEntry.hi.target != TGT_NONE) begin
                    moveStart <= 1'b1;
                    moveBusy <= 1'b1;
                    activeTarget <= curEntry.hi.target;
                    activeRegDist <= curEntry.lo.regDistSet;
                    moveCmd.step <= curStep;
                    moveCmd.target <= curEntry.hi.target;
                    // older revisions run on the default ramps
                    moveCmd.accel <= (FW_REVISION >= FW_REV_ACCEL) ? curEntry.hi.accel : 4'h0; // [R14]
                    moveCmd.decel <= (FW_REVISION >= FW_REV_ACCEL) ? curEntry.hi.decel : 4'h0; // [R14]
                  end
                end
              end
              PH_TRIG: begin
                if (trigActive) begin
                  phase <= PH_WAIT; // [R17]
                end
              end
              PH_WAIT: begin
                if (timerDone) begin
                  if (advEnd) begin
                    seqState <= SEQ_CANCELLED; // [R16]
                  end else begin
                    curStep <= advStep; // [R15]
                    loopLeft <= advLoop;
                    phase <= PH_ISSUE;
                  end
                end
              end
            endcase
          end
        end
        SEQ_STOPPED: begin
          if (runRise) begin
            // no wait on motion_done: a decelerating motor is picked up again
            seqState <= SEQ_OPERATING; // [R7] [R8]
            phase <= PH_DELAY;
            errStop <= 1'b0;
            if (errStop) begin
              if (advEnd) begin
                seqState <= SEQ_CANCELLED;
              end else begin
                curStep <= advStep; // [R2] [R11]
                loopLeft <= advLoop;
              end
            end
          end else if (cancelRise && !runLevel) begin
            seqState <= SEQ_CANCELLED; // [R9]
          end
        end
        default: seqState <= SEQ_CANCELLED;
      endcase
    end
  end

  // apb access: one wait state, write lands on the completing edge
  logic apbDone;
  logic apbWrite;
  logic regHit;
  logic tableCommit;
  logic lockedSet;
  logic [31:0] readData;

  assign apbDone = psel && penable && pready;
  assign apbWrite = apbDone && pwrite;
  assign regHit = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_STEP_INDEX)
    || (paddr == REG_STEP_LO) || (paddr == REG_STEP_HI);
  assign tableCommit = apbWrite && (paddr == REG_STEP_HI) && (seqState == SEQ_CANCELLED); // [R4]
  assign lockedSet = apbWrite && (paddr == REG_STEP_HI) && (seqState != SEQ_CANCELLED); // [R4]

  always_comb begin
    readData = 32'h0000_0000;
    unique case (paddr)
      REG_STATUS: readData = {loopLeft, curStep, 2'b00, moveBusy, errStop,
        tableLockedError, sequencingConflictError, seqState};
      REG_STEP_INDEX: readData = {25'h000_0000, stepIndex};
      REG_STEP_LO: readData = idxEntry.lo;
      REG_STEP_HI: readData = idxEntry.hi;
      default: readData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : readData;
        pslverr <= !regHit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stepIndex <= '0;
      stagedLo <= '0;
      stepValid <= '0;
    end else if (apbWrite) begin
      if (paddr == REG_STEP_INDEX) begin
        stepIndex <= pwdata[STEP_W-1:0];
      end
      if (paddr == REG_STEP_LO) begin
        stagedLo <= pwdata;
      end
      if (tableCommit) begin
        stepValid[stepIndex] <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (tableCommit) begin
      stepTable[stepIndex] <= {pwdata, stagedLo};
    end
  end

  // sticky errors: a new set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sequencingConflictError <= 1'b0;
      tableLockedError <= 1'b0;
    end else begin
      if (conflict) begin
        sequencingConflictError <= 1'b1; // [R1]
      end else if (apbWrite && (paddr == REG_CTRL) && pwdata[CTRL_CLR_CONFLICT]) begin
        sequencingConflictError <= 1'b0;
      end
      if (lockedSet) begin
        tableLockedError <= 1'b1; // [R4]
      end else if (apbWrite && (paddr == REG_CTRL) && pwdata[CTRL_CLR_LOCKED]) begin
        tableLockedError <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  logic [31:0] respCount;
  logic respSpecial;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      respCount <= '0;
      respSpecial <= 1'b0;
    end else if (restart) begin
      respCount <= 32'h0000_0001;
      respSpecial <= (seqState == SEQ_STOPPED);
    end else if (moveStart) begin
      // only the first move after a start is timed
      respCount <= 32'h0000_0000;
    end else if (respCount != 32'h0000_0000) begin
      respCount <= respCount + 32'h0000_0001;
    end
  end

  sequence s_err_halted;
    (seqState == SEQ_STOPPED) && errStop;
  endsequence
  sequence s_rerun;
    runRise;
  endsequence

  a_state_legal: assert property (seqState inside {SEQ_CANCELLED, SEQ_OPERATING, SEQ_STOPPED}) // [R10]
    else $error("sequencer state outside the three legal states");
  a_conflict_halt: assert property (conflict |=> seqState == SEQ_STOPPED && sequencingConflictError && moveStop) // [R1]
    else $error("conflict did not halt with error");
  a_locked_edit: assert property (lockedSet |=> tableLockedError && $stable(stepValid)) // [R4]
    else $error("table edit accepted outside cancelled state");
  a_start_capture: assert property ((seqState == SEQ_CANCELLED && runRise) |=> curStep == $past(stepSelect)) // [R5]
    else $error("start step not taken from select lines");
  a_stop_fall: assert property ((seqState == SEQ_OPERATING && runFall) |=> seqState == SEQ_STOPPED && moveStop) // [R6]
    else $error("run drop did not stop the program");
  a_resume_same: assert property ((seqState == SEQ_STOPPED && !errStop && runRise)
    |=> seqState == SEQ_OPERATING && $stable(curStep) ##1 phase == PH_DELAY) // [R7]
    else $error("resume changed the step");
  a_skip_failed: assert property ((s_err_halted ##0 s_rerun)
    |=> (curStep == $past(advStep) || seqState == SEQ_CANCELLED)) // [R11]
    else $error("error resume did not skip to successor");
  a_cancel_edge: assert property ((seqState == SEQ_STOPPED && cancelRise && !runLevel && !runRise)
    |=> seqState == SEQ_CANCELLED) // [R9]
    else $error("cancel edge ignored while stopped");
  a_resp_window: assert property ((moveStart && !respSpecial && respCount != 0)
    |-> respCount >= RESP_MIN_MS * CYCLES_PER_MS && respCount <= RESP_MOTION_MAX_MS * CYCLES_PER_MS) // [R12]
    else $error("motion response outside normal window");
  a_resp_special: assert property ((moveStart && respSpecial && respCount != 0)
    |-> respCount >= RESP_MIN_MS * CYCLES_PER_MS && respCount <= RESP_MOTION_SPECIAL_MS * CYCLES_PER_MS) // [R13]
    else $error("response outside special window");
  a_ramp_rev: assert property (moveStart && FW_REVISION < FW_REV_ACCEL |-> moveCmd.accel == 4'h0) // [R14]
    else $error("ramp fields used on old revision");
endmodule
`default_nettype wire

// ==== tb/iss_motion_model.sv ====
/*
  Motion unit stand-in: answers each issued move with done and in-position.
  Assumes moveStart is a one-cycle pulse; slow holds a move open indefinitely.
*/
`timescale 1ns/1ns
`default_nettype none
module iss_motion_model
  import iss_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // from the sequencer, and slow from the bench
  input wire logic moveStart,
  input wire logic moveStop,
  input wire logic slow,
  // feedback
  output iss_motion_fb_t motionFb
);
  logic [3:0] cnt;

  // a stop settles the motor at once, except when slow leaves it coasting
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 4'h0;
      motionFb <= '0;
    end else if (moveStart) begin
      cnt <= 4'h8;
      motionFb <= '0;
    end else if (moveStop && !slow) begin
      cnt <= 4'h0;
      motionFb <= '1;
    end else if (!slow && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        motionFb <= '1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/indexer_step_sequencer_bench.sv ====
/*
  Self-checking bench: APB table edits, run/stop/cancel, errors, response times.
  Assumes one 20 MHz clock and a shortened 20-cycle millisecond.
*/
`timescale 1ns/1ns
`default_nettype none
module indexer_step_sequencer_bench;
  import iss_pkg::*;
  localparam int MS = 20;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic runRequest, programCancel, moveStart, moveStop, slow;
  logic sequencingConflictError, tableLockedError;
  logic [STEP_W-1:0] stepSelect;
  logic [4:0] programmableOutputs;
  iss_motion_fb_t motionFb;
  iss_move_t moveCmd;
  iss_seq_t seqState;
  int fails, checkCount, n;

  iss_step_sequencer #(.CYCLES_PER_MS(MS), .FW_REVISION(4)) uut (.mclk(mclk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .runRequest(runRequest),
    .programCancel(programCancel), .stepSelect(stepSelect), .motionFb(motionFb),
    .moveCmd(moveCmd), .moveStart(moveStart), .moveStop(moveStop),
    .programmableOutputs(programmableOutputs), .seqState(seqState),
    .sequencingConflictError(sequencingConflictError), .tableLockedError(tableLockedError));

  iss_motion_model motion (.mclk(mclk), .nrst(nrst), .moveStart(moveStart),
    .moveStop(moveStop), .slow(slow), .motionFb(motionFb));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic end_of_test;
    if (fails == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // cycle counts against a window
  task automatic chk_in(input int got, input int lo, input int hi);
    checkCount++;
    if (got < lo || got > hi) begin
      fails++;
      $display("mismatch at %0t got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_in(k, 1, 49);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic wait_state(input iss_seq_t s, input int lim);
    n = 0;
    while (seqState !== s && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic wait_start;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (moveStart !== 1'b1 && n < 400);
  endtask

  task automatic t_reset;
    chk(seqState, SEQ_CANCELLED);
    chk({moveStart, moveStop, sequencingConflictError, tableLockedError}, 32'h0000_0000);
  endtask

  task automatic t_regs;
    apb(1'b0, 8'h40, 32'h0000_0000, rd, er);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
    chk(rd[3:0], 4'h0);
  endtask

  // step 3: one finite pass, then terminate back to cancelled
  task automatic t_terminate;
    wr(REG_STEP_INDEX, 32'h0000_0003);
    wr(REG_STEP_LO, 32'h4000_0000);
    wr(REG_STEP_HI, 32'h0000_AA65);
    slow <= 1'b0;
    stepSelect <= 7'h03;
    runRequest <= 1'b1;
    wait_start;
    chk_in(n, 2 * MS, 6 * MS);
    chk(moveCmd.step, 7'h03);
    chk({moveCmd.accel, moveCmd.decel, 3'h0, programmableOutputs}, 16'h5305);
    wait_state(SEQ_CANCELLED, 100);
    chk(seqState, SEQ_CANCELLED);
    runRequest <= 1'b0;
    repeat (5) @(posedge mclk);
  endtask

  task automatic t_stop_resume;
    slow <= 1'b1;
    runRequest <= 1'b1;
    wait_start;
    wr(REG_STEP_HI, 32'h0000_0000);
    @(posedge mclk);
    chk(tableLockedError, 1'b1);
    wr(REG_CTRL, 32'h0000_0002);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
    chk(rd[3], 1'b0);
    runRequest <= 1'b0;
    stepSelect <= 7'h11;
    wait_state(SEQ_STOPPED, 20);
    chk(seqState, SEQ_STOPPED);
    runRequest <= 1'b1;
    wait_start;
    chk_in(n, 2 * MS, 16 * MS);
    chk(moveCmd.step, 7'h03);
    runRequest <= 1'b0;
    wait_state(SEQ_STOPPED, 20);
    programCancel <= 1'b1;
    wait_state(SEQ_CANCELLED, 20);
    chk(seqState, SEQ_CANCELLED);
    programCancel <= 1'b0;
  endtask

  // step 5 repeats on select line 1 while its finite move is still open
  task automatic t_conflict;
    wr(REG_STEP_INDEX, 32'h0000_0005);
    wr(REG_STEP_LO, 32'h0332_0000);
    wr(REG_STEP_HI, 32'h0001_2000);
    stepSelect <= 7'h05;
    runRequest <= 1'b1;
    wait_start;
    chk(moveCmd.step, 7'h05);
    stepSelect <= 7'h07;
    wait_state(SEQ_STOPPED, 60);
    chk(seqState, SEQ_STOPPED);
    chk(sequencingConflictError, 1'b1);
    runRequest <= 1'b0;
    repeat (5) @(posedge mclk);
    wr(REG_CTRL, 32'h0000_0001);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
    chk(rd[2], 1'b0);
    runRequest <= 1'b1;
    repeat (5) @(posedge mclk);
    apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
    chk({rd[14:8], rd[4], rd[1:0]}, {7'h06, 1'b0, 2'h1});
    runRequest <= 1'b0;
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    runRequest = 1'b0;
    programCancel = 1'b0;
    stepSelect = 7'h00;
    slow = 1'b0;
    fails = 0;
    checkCount = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_regs;
    t_terminate;
    t_stop_resume;
    t_conflict;
    end_of_test;
  end

  // whole run needs a few hundred cycles; cut off at 20000
  initial begin
    #1_000_000;
    fails++;
    end_of_test;
  end
endmodule
`default_nettype wire
